// ===== logic/i2cs_pkg.sv
/*
  Shared constants and types for the I2C slave control block.
  Assumes a single 10 MHz system clock and an active-low async reset.
*/
package i2cs_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;
  localparam logic [15:0] TMR_RESET = 16'h0000;
  localparam logic [15:0] TMR_MAX = 16'hffff;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] UNDERRUN_FILL = 8'hff;
  // Reload source code that ties the timer to the SCL-low timeout
  localparam logic TMR_RLD_SRC_SCL = 1'b1;
  localparam logic PIN_MODE_GPIO = 1'b0;
  localparam logic PIN_MODE_I2C = 1'b1;
  localparam logic PRELOAD_DIS_RESET = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_STRETCH,
    ST_TX,
    ST_TX_ACK,
    ST_RX,
    ST_RX_ACK
  } i2cs_state_t;
endpackage

// ===== logic/i2cs_tmr_if.sv
/*
  Link between the slave controller and its SCL-low timeout timer.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
interface i2cs_tmr_if;
  logic sclLow;
  logic timeoutMode;
  logic run;
  logic [15:0] reload;
  logic [15:0] count;
  logic overflow;

  modport ctrl (
    output sclLow,
    output timeoutMode,
    output run,
    output reload,
    input count,
    input overflow
  );

  modport timer (
    input sclLow,
    input timeoutMode,
    input run,
    input reload,
    output count,
    output overflow
  );
endinterface

// ===== logic/i2cs_timeout_timer.sv
/*
  General-purpose 16-bit up counter with auto-reload, doubling as the
  SCL-low timeout timer. Assumes sclLow is already synchronised.
*/
`timescale 1ns/1ps
module i2cs_timeout_timer (
  input wire logic clock,
  input wire logic rst_b,
  i2cs_tmr_if.timer tmr
);
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic overflow_r;
  logic overflow_nxt;

  always_comb
  begin
    count_nxt = count_r;
    overflow_nxt = 1'b0;
    if (tmr.timeoutMode && !tmr.sclLow)
    begin
      // Held at reload while the line is high
      count_nxt = tmr.reload;
    end
    else if (tmr.run || tmr.timeoutMode)
    begin
      if (count_r == i2cs_pkg::TMR_MAX)
      begin
        count_nxt = tmr.reload;
        overflow_nxt = 1'b1;
      end
      else
      begin
        count_nxt = count_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      count_r <= i2cs_pkg::TMR_RESET;
      overflow_r <= 1'b0;
    end
    else
    begin
      count_r <= count_nxt;
      overflow_r <= overflow_nxt;
    end
  end

  assign tmr.count = count_r;
  assign tmr.overflow = overflow_r;
endmodule

// ===== logic/i2cs_slave_ctrl.sv
/*
  I2C slave byte engine with pin-mode mux, busy NACK, transmit preload
  handling and SCL-low timeout. Assumes open-drain pads resolved outside;
  control bits and GPIO drive come from logic on the same clock.
*/
`timescale 1ns/1ps
module i2cs_slave_ctrl (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic pinSclIn,
  input wire logic pinSdaIn,
  output logic pinSclOut,
  output logic pinSclOe,
  output logic pinSdaOut,
  output logic pinSdaOe,
  input wire logic pinFunctionSelect,
  input wire logic slaveEnable,
  input wire logic busy,
  input wire logic preloadDisable,
  input wire logic timeoutEnable,
  input wire logic timerReloadSourceSel,
  input wire logic timerRun,
  input wire logic [15:0] timerReload,
  input wire logic [6:0] slaveAddr,
  input wire logic gpioSclOut,
  input wire logic gpioSclOe,
  input wire logic gpioSdaOut,
  input wire logic gpioSdaOe,
  output logic gpioSclIn,
  output logic gpioSdaIn,
  input wire logic [7:0] slaveTxDataReg,
  input wire logic slaveTxDataWrite,
  output logic txFull,
  output logic txRequest,
  output logic txUnderrun,
  output logic [7:0] rxData,
  output logic rxValid,
  output logic addressed,
  output logic timeoutEvent,
  output logic [15:0] timerCount
);
  i2cs_tmr_if tmrLink();

  i2cs_timeout_timer u_timer (
    .clock(clock),
    .rst_b(rst_b),
    .tmr(tmrLink.timer)
  );

  // Synchronisers; stage one feeds stage two only
  logic sclMeta_r;
  logic sdaMeta_r;
  logic sclS_r;
  logic sdaS_r;
  logic sclP_r;
  logic sdaP_r;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sclMeta_r <= 1'b1;
      sdaMeta_r <= 1'b1;
      sclS_r <= 1'b1;
      sdaS_r <= 1'b1;
      sclP_r <= 1'b1;
      sdaP_r <= 1'b1;
    end
    else
    begin
      sclMeta_r <= pinSclIn;
      sdaMeta_r <= pinSdaIn;
      sclS_r <= sclMeta_r;
      sdaS_r <= sdaMeta_r;
      sclP_r <= sclS_r;
      sdaP_r <= sdaS_r;
    end
  end

  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic engineOn;
  assign sclRise = sclS_r && !sclP_r;
  assign sclFall = !sclS_r && sclP_r;
  assign startSeen = sclS_r && sclP_r && sdaP_r && !sdaS_r;
  assign stopSeen = sclS_r && sclP_r && !sdaP_r && sdaS_r;
  assign engineOn = slaveEnable && (pinFunctionSelect == i2cs_pkg::PIN_MODE_I2C);

  assign tmrLink.sclLow = !sclS_r;
  assign tmrLink.timeoutMode = timeoutEnable && (timerReloadSourceSel == i2cs_pkg::TMR_RLD_SRC_SCL);
  assign tmrLink.run = timerRun;
  assign tmrLink.reload = timerReload;

  i2cs_pkg::i2cs_state_t state_r;
  i2cs_pkg::i2cs_state_t state_nxt;
  logic [3:0] bitCnt_r;
  logic [3:0] bitCnt_nxt;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic readOp_r;
  logic readOp_nxt;
  logic masterNack_r;
  logic masterNack_nxt;
  logic sdaDrive_r;
  logic sdaDrive_nxt;
  logic sclHold_r;
  logic sclHold_nxt;
  logic [7:0] txByte_r;
  logic [7:0] txByte_nxt;
  logic txFull_r;
  logic txFull_nxt;
  logic txRequest_r;
  logic txRequest_nxt;
  logic txUnderrun_r;
  logic txUnderrun_nxt;
  logic [7:0] rxData_r;
  logic [7:0] rxData_nxt;
  logic rxValid_r;
  logic rxValid_nxt;
  logic addressed_r;
  logic addressed_nxt;
  logic timeout_r;
  logic pinSclOut_r;
  logic pinSclOe_r;
  logic pinSdaOut_r;
  logic pinSdaOe_r;
  logic txLoad;

  always_comb
  begin
    state_nxt = state_r;
    bitCnt_nxt = bitCnt_r;
    shift_nxt = shift_r;
    readOp_nxt = readOp_r;
    masterNack_nxt = masterNack_r;
    sdaDrive_nxt = sdaDrive_r;
    sclHold_nxt = sclHold_r;
    txUnderrun_nxt = 1'b0;
    rxData_nxt = rxData_r;
    rxValid_nxt = 1'b0;
    addressed_nxt = addressed_r;
    txLoad = 1'b0;
    if (!engineOn || stopSeen)
    begin
      state_nxt = i2cs_pkg::ST_IDLE;
      sdaDrive_nxt = 1'b0;
      sclHold_nxt = 1'b0;
      addressed_nxt = 1'b0;
    end
    else if (startSeen)
    begin
      state_nxt = i2cs_pkg::ST_ADDR;
      bitCnt_nxt = 4'h0;
      sdaDrive_nxt = 1'b0;
      sclHold_nxt = 1'b0;
      addressed_nxt = 1'b0;
    end
    else
    begin
      unique case (state_r)
        i2cs_pkg::ST_IDLE:
        begin
          sdaDrive_nxt = 1'b0;
        end
        i2cs_pkg::ST_ADDR:
        begin
          if (sclRise)
          begin
            shift_nxt = {shift_r[6:0], sdaS_r};
            bitCnt_nxt = bitCnt_r + 4'h1;
          end
          else if (sclFall && bitCnt_r == i2cs_pkg::BYTE_BITS)
          begin
            if (shift_r[7:1] == slaveAddr && !busy)
            begin
              sdaDrive_nxt = 1'b1;
              readOp_nxt = shift_r[0];
              addressed_nxt = 1'b1;
              state_nxt = i2cs_pkg::ST_ADDR_ACK;
              // Byte should be waiting by now when preload is on
              txUnderrun_nxt = shift_r[0] && !preloadDisable && !txFull_r;
            end
            else
            begin
              state_nxt = i2cs_pkg::ST_IDLE;
            end
          end
        end
        i2cs_pkg::ST_ADDR_ACK,
        i2cs_pkg::ST_TX_ACK:
        begin
          if (sclRise)
          begin
            masterNack_nxt = (state_r == i2cs_pkg::ST_TX_ACK) && sdaS_r;
          end
          else if (sclFall)
          begin
            sdaDrive_nxt = 1'b0;
            bitCnt_nxt = 4'h0;
            if (busy && state_r == i2cs_pkg::ST_ADDR_ACK && !readOp_r)
            begin
              state_nxt = i2cs_pkg::ST_RX;
            end
            else if (!readOp_r)
            begin
              state_nxt = i2cs_pkg::ST_RX;
            end
            else if (masterNack_r)
            begin
              state_nxt = i2cs_pkg::ST_IDLE;
            end
            else if (txFull_r)
            begin
              txLoad = 1'b1;
              shift_nxt = txByte_r;
              sdaDrive_nxt = !txByte_r[7];
              state_nxt = i2cs_pkg::ST_TX;
            end
            else if (preloadDisable)
            begin
              // Clock stretch gives firmware time to supply the byte
              sclHold_nxt = 1'b1;
              state_nxt = i2cs_pkg::ST_STRETCH;
            end
            else
            begin
              shift_nxt = i2cs_pkg::UNDERRUN_FILL;
              sdaDrive_nxt = 1'b0;
              state_nxt = i2cs_pkg::ST_TX;
            end
          end
        end
        i2cs_pkg::ST_STRETCH:
        begin
          if (txFull_r)
          begin
            txLoad = 1'b1;
            shift_nxt = txByte_r;
            sdaDrive_nxt = !txByte_r[7];
            // SCL held one more cycle so SDA settles before the master sees a rise
            state_nxt = i2cs_pkg::ST_TX;
          end
        end
        i2cs_pkg::ST_TX:
        begin
          sclHold_nxt = 1'b0;
          if (sclFall)
          begin
            if (bitCnt_r == i2cs_pkg::LAST_TX_BIT)
            begin
              sdaDrive_nxt = 1'b0;
              state_nxt = i2cs_pkg::ST_TX_ACK;
            end
            else
            begin
              bitCnt_nxt = bitCnt_r + 4'h1;
              shift_nxt = {shift_r[6:0], 1'b1};
              sdaDrive_nxt = !shift_r[6];
            end
          end
        end
        i2cs_pkg::ST_RX:
        begin
          if (sclRise)
          begin
            shift_nxt = {shift_r[6:0], sdaS_r};
            bitCnt_nxt = bitCnt_r + 4'h1;
          end
          else if (sclFall && bitCnt_r == i2cs_pkg::BYTE_BITS)
          begin
            if (!busy)
            begin
              rxData_nxt = shift_r;
              rxValid_nxt = 1'b1;
            end
            sdaDrive_nxt = !busy;
            state_nxt = i2cs_pkg::ST_RX_ACK;
          end
        end
        i2cs_pkg::ST_RX_ACK:
        begin
          if (sclFall)
          begin
            sdaDrive_nxt = 1'b0;
            bitCnt_nxt = 4'h0;
            state_nxt = i2cs_pkg::ST_RX;
          end
        end
      endcase
    end
  end

  always_comb
  begin
    // A write in the load cycle keeps the new byte
    txByte_nxt = slaveTxDataWrite ? slaveTxDataReg : txByte_r;
    txFull_nxt = slaveTxDataWrite || (txFull_r && !txLoad);
    txRequest_nxt = (state_nxt == i2cs_pkg::ST_STRETCH) && !txFull_nxt;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r <= i2cs_pkg::ST_IDLE;
      bitCnt_r <= 4'h0;
      shift_r <= i2cs_pkg::BYTE_RESET;
      readOp_r <= 1'b0;
      masterNack_r <= 1'b0;
      sdaDrive_r <= 1'b0;
      sclHold_r <= 1'b0;
      txByte_r <= i2cs_pkg::BYTE_RESET;
      txFull_r <= 1'b0;
      txRequest_r <= 1'b0;
      txUnderrun_r <= 1'b0;
      rxData_r <= i2cs_pkg::BYTE_RESET;
      rxValid_r <= 1'b0;
      addressed_r <= 1'b0;
      timeout_r <= 1'b0;
      pinSclOut_r <= 1'b0;
      pinSclOe_r <= 1'b0;
      pinSdaOut_r <= 1'b0;
      pinSdaOe_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      bitCnt_r <= bitCnt_nxt;
      shift_r <= shift_nxt;
      readOp_r <= readOp_nxt;
      masterNack_r <= masterNack_nxt;
      sdaDrive_r <= sdaDrive_nxt;
      sclHold_r <= sclHold_nxt;
      txByte_r <= txByte_nxt;
      txFull_r <= txFull_nxt;
      txRequest_r <= txRequest_nxt;
      txUnderrun_r <= txUnderrun_nxt;
      rxData_r <= rxData_nxt;
      rxValid_r <= rxValid_nxt;
      addressed_r <= addressed_nxt;
      timeout_r <= tmrLink.overflow && tmrLink.timeoutMode;
      if (pinFunctionSelect == i2cs_pkg::PIN_MODE_GPIO)
      begin
        pinSclOut_r <= gpioSclOut;
        pinSclOe_r <= gpioSclOe;
        pinSdaOut_r <= gpioSdaOut;
        pinSdaOe_r <= gpioSdaOe;
      end
      else
      begin
        // Open drain: only ever pull low
        pinSclOut_r <= 1'b0;
        pinSclOe_r <= sclHold_nxt;
        pinSdaOut_r <= 1'b0;
        pinSdaOe_r <= sdaDrive_nxt;
      end
    end
  end

  assign pinSclOut = pinSclOut_r;
  assign pinSclOe = pinSclOe_r;
  assign pinSdaOut = pinSdaOut_r;
  assign pinSdaOe = pinSdaOe_r;
  assign gpioSclIn = sclS_r;
  assign gpioSdaIn = sdaS_r;
  assign txFull = txFull_r;
  assign txRequest = txRequest_r;
  assign txUnderrun = txUnderrun_r;
  assign rxData = rxData_r;
  assign rxValid = rxValid_r;
  assign addressed = addressed_r;
  assign timeoutEvent = timeout_r;
  assign timerCount = tmrLink.count;
endmodule

// ===== test/i2cs_assertions.sv
/*
  Checker for the I2C slave control block.
  Assumes binding to i2cs_slave_ctrl; sees its ports only.
*/
`timescale 1ns/1ps
module i2cs_assertions (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic pinSclOut,
  input wire logic pinSclOe,
  input wire logic pinSdaOut,
  input wire logic pinSdaOe,
  input wire logic pinFunctionSelect,
  input wire logic slaveEnable,
  input wire logic busy,
  input wire logic timeoutEnable,
  input wire logic timerReloadSourceSel,
  input wire logic [15:0] timerReload,
  input wire logic gpioSclOut,
  input wire logic gpioSclOe,
  input wire logic gpioSclIn,
  input wire logic slaveTxDataWrite,
  input wire logic txRequest,
  input wire logic rxValid,
  input wire logic addressed,
  input wire logic timeoutEvent,
  input wire logic [15:0] timerCount
);
  wire tm = timeoutEnable && (timerReloadSourceSel == i2cs_pkg::TMR_RLD_SRC_SCL);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_gpioHeld;
    !pinFunctionSelect ##1 !pinFunctionSelect;
  endsequence
  sequence s_lowRun;
    (tm && !gpioSclIn)[*4] ##0 timerCount != i2cs_pkg::TMR_MAX;
  endsequence
  property p_gpio;
    s_gpioHeld |-> pinSclOe == $past(gpioSclOe) && pinSclOut == $past(gpioSclOut);
  endproperty
  a_gpio: assert property (p_gpio) else $error("pins ignore gpio drive");
  property p_i2cPins;
    pinFunctionSelect ##1 pinFunctionSelect |-> !pinSclOut && !pinSdaOut;
  endproperty
  a_i2cPins: assert property (p_i2cPins) else $error("pin drives high in bus mode");
  property p_off;
    (pinFunctionSelect && !slaveEnable)[*3] |-> !pinSclOe && !pinSdaOe;
  endproperty
  a_off: assert property (p_off) else $error("disabled slave drives pins");
  property p_busy;
    (pinFunctionSelect && busy && !addressed)[*2] |-> !$rose(pinSdaOe);
  endproperty
  a_busy: assert property (p_busy) else $error("busy slave acknowledged");
  property p_rxAck;
    rxValid |-> pinSdaOe && !$past(busy);
  endproperty
  a_rxAck: assert property (p_rxAck) else $error("received byte not acknowledged");
  property p_stretch;
    txRequest |-> pinSclOe;
  endproperty
  a_stretch: assert property (p_stretch) else $error("request without stretch");
  property p_unstretch;
    txRequest && slaveTxDataWrite |-> ##[1:3] !txRequest;
  endproperty
  a_unstretch: assert property (p_unstretch) else $error("late byte not taken");
  property p_reload;
    (tm && gpioSclIn && $stable(timerReload))[*4] |-> timerCount == timerReload;
  endproperty
  a_reload: assert property (p_reload) else $error("timer not held at reload");
  property p_count;
    s_lowRun |=> timerCount == $past(timerCount) + 16'h0001;
  endproperty
  a_count: assert property (p_count) else $error("timer not counting");
  property p_quiet;
    (!tm)[*3] |-> !timeoutEvent;
  endproperty
  a_quiet: assert property (p_quiet) else $error("timeout while disabled");
endmodule
bind i2cs_slave_ctrl i2cs_assertions i_i2cs_assertions (.clock, .rst_b, .pinSclOut, .pinSclOe,
  .pinSdaOut, .pinSdaOe, .pinFunctionSelect, .slaveEnable, .busy, .timeoutEnable, .timerReloadSourceSel,
  .timerReload, .gpioSclOut, .gpioSclOe, .gpioSclIn, .slaveTxDataWrite, .txRequest, .rxValid,
  .addressed, .timeoutEvent, .timerCount);

// ===== test/i2cs_master_model.sv
/*
  Behavioural I2C bus master; pulls lines low or releases them.
  Assumes pull-ups on the bench wires.
*/
`timescale 1ns/1ps
module i2cs_master_model (
  input wire logic clock,
  input wire logic scl,
  input wire logic sda,
  output logic sclPull,
  output logic sdaPull
);
  int hangs = 0;
  initial
  begin
    sclPull = 1'b0;
    sdaPull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Stretch wait is bounded so a stuck slave cannot hang the run
  task automatic sclRise();
    int k;
    sclPull <= 1'b0;
    k = 0;
    tick(1);
    while (scl !== 1'b1 && k < 4000)
    begin
      tick(1);
      k++;
    end
    hangs += int'(k == 4000);
    tick(8);
  endtask
  task automatic bitIo(input logic b, output logic r);
    sdaPull <= !b;
    tick(8);
    sclRise();
    r = sda;
    sclPull <= 1'b1;
    tick(8);
  endtask
  task automatic xfer(input logic [7:0] w, input logic mAck, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--)
      bitIo(w[i], r[i]);
    bitIo(mAck, ack);
  endtask
  task automatic start();
    sdaPull <= 1'b1;
    tick(8);
    sclPull <= 1'b1;
    tick(8);
  endtask
  task automatic stop();
    sdaPull <= 1'b1;
    tick(8);
    sclRise();
    sdaPull <= 1'b0;
    tick(8);
  endtask
  task automatic holdLow(input int n);
    sclPull <= 1'b1;
    tick(n);
    sclPull <= 1'b0;
    tick(8);
  endtask
endmodule

// ===== test/i2cs_slave_ctrl_bench.sv
/*
  Self-checking bench for the I2C slave control block.
  Assumes the master model and the bound checker.
*/
`timescale 1ns/1ps
module i2cs_slave_ctrl_bench;
  logic [6:0] own = 7'h3a;
  logic wrongAddr = 1'b0;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic pinFunctionSelect, slaveEnable, busy, preloadDisable, timeoutEnable, timerReloadSourceSel, timerRun;
  logic gpioSclOut, gpioSclOe, gpioSdaOut, gpioSdaOe, slaveTxDataWrite, sclPull, sdaPull;
  logic pinSclOut, pinSclOe, pinSdaOut, pinSdaOe, gpioSclIn, gpioSdaIn, txFull, txRequest, txUnderrun;
  logic rxValid, addressed, timeoutEvent, ack;
  logic [15:0] timerReload, timerCount;
  logic [7:0] slaveTxDataReg, rxData, rd, d;
  logic [31:0] seed = 32'h00000020;
  logic [7:0] rxQ[$];
  int miscompares = 0;
  int totalChecks = 0;
  int events = 0;
  int underruns = 0;
  wire sclW = !sclPull && !(pinSclOe && !pinSclOut);
  wire sdaW = !sdaPull && !(pinSdaOe && !pinSdaOut);
  always #50 clock = !clock;
  i2cs_slave_ctrl i_i2cs_slave_ctrl (.clock, .rst_b, .pinSclIn(sclW), .pinSdaIn(sdaW), .pinSclOut,
    .pinSclOe, .pinSdaOut, .pinSdaOe, .pinFunctionSelect, .slaveEnable, .busy, .preloadDisable,
    .timeoutEnable, .timerReloadSourceSel, .timerRun, .timerReload, .slaveAddr(own), .gpioSclOut,
    .gpioSclOe, .gpioSdaOut, .gpioSdaOe, .gpioSclIn, .gpioSdaIn, .slaveTxDataReg, .slaveTxDataWrite,
    .txFull, .txRequest, .txUnderrun, .rxData, .rxValid, .addressed, .timeoutEvent, .timerCount);
  i2cs_master_model i_i2cs_master_model (.clock, .scl(sclW), .sda(sdaW), .sclPull, .sdaPull);
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
    totalChecks++;
    if (s !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finalReport();
    $display("checks %0d miscompares %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic addrPhase(input logic rw, input logic expAck);
    i_i2cs_master_model.start();
    i_i2cs_master_model.xfer({own ^ {6'h00, wrongAddr}, rw}, 1'b1, rd, ack);
    check("address ack", 16'(ack), 16'(expAck));
    check("addressed", 16'(addressed), 16'(!expAck));
  endtask
  task automatic txWrite(input logic [7:0] b);
    slaveTxDataReg <= b;
    slaveTxDataWrite <= 1'b1;
    i_i2cs_master_model.tick(1);
    slaveTxDataWrite <= 1'b0;
  endtask
  // Late sampling keeps the watcher clear of the edge that updates outputs
  always @(negedge clock)
  begin
    if (rxValid === 1'b1)
      check("rxData", 16'(rxData), rxQ.size() > 0 ? 16'(rxQ.pop_front()) : 16'hdead);
    if (timeoutEvent === 1'b1)
      events++;
    if (txUnderrun === 1'b1)
      underruns++;
  end
  initial
  begin
    i_i2cs_master_model.tick(90000);
    miscompares++;
    finalReport();
  end
  initial
  begin
    {pinFunctionSelect, slaveEnable, busy, timeoutEnable, timerReloadSourceSel, timerRun} = 6'h00;
    {gpioSclOut, gpioSclOe, gpioSdaOut, gpioSdaOe, slaveTxDataWrite} = 5'h00;
    preloadDisable = 1'b1;
    timerReload = 16'h0000;
    slaveTxDataReg = 8'h00;
    i_i2cs_master_model.tick(16);
    rst_b <= 1'b1;
    i_i2cs_master_model.tick(4);
    d = xs();
    {gpioSclOut, gpioSclOe, gpioSdaOut, gpioSdaOe} <= d[3:0];
    timerRun <= d[4];
    own <= 7'(xs());
    i_i2cs_master_model.tick(6);
    check("gpio pins", 16'({pinSclOut, pinSclOe, pinSdaOut, pinSdaOe}), 16'(d[3:0]));
    check("gpio inputs", 16'({gpioSclIn, gpioSdaIn}), 16'({!(d[2] && !d[3]), !(d[0] && !d[1])}));
    {gpioSclOe, gpioSdaOe} <= 2'h0;
    pinFunctionSelect <= 1'b1;
    i_i2cs_master_model.tick(4);
    slaveEnable <= 1'b1;
    i_i2cs_master_model.tick(8);
    for (int b = 0; b < 3; b++)
    begin
      busy <= (b == 1);
      wrongAddr = (b == 2);
      i_i2cs_master_model.tick(2);
      d = xs();
      addrPhase(1'b0, b != 0);
      if (b == 0)
        rxQ.push_back(d);
      i_i2cs_master_model.xfer(d, 1'b1, rd, ack);
      check("data ack", 16'(ack), 16'(b != 0));
      i_i2cs_master_model.stop();
    end
    wrongAddr = 1'b0;
    busy <= 1'b0;
    preloadDisable <= 1'b0;
    d = xs();
    txWrite(d);
    i_i2cs_master_model.tick(1);
    check("txFull", 16'(txFull), 16'h0001);
    addrPhase(1'b1, 1'b0);
    i_i2cs_master_model.xfer(8'hff, 1'b1, rd, ack);
    check("preloaded byte", 16'(rd), 16'(d));
    i_i2cs_master_model.stop();
    addrPhase(1'b1, 1'b0);
    i_i2cs_master_model.xfer(8'hff, 1'b1, rd, ack);
    check("underrun fill", 16'(rd), 16'(i2cs_pkg::UNDERRUN_FILL));
    check("underrun pulse", 16'(underruns), 16'h0001);
    i_i2cs_master_model.stop();
    preloadDisable <= 1'b1;
    d = xs();
    addrPhase(1'b1, 1'b0);
    fork
      i_i2cs_master_model.xfer(8'hff, 1'b1, rd, ack);
      begin
        for (int k = 0; k < 2000 && txRequest !== 1'b1; k++)
          i_i2cs_master_model.tick(1);
        check("txRequest", 16'(txRequest), 16'h0001);
        if (txRequest !== 1'b1)
          finalReport();
        txWrite(d);
      end
    join
    check("late byte", 16'(rd), 16'(d));
    i_i2cs_master_model.stop();
    slaveEnable <= 1'b0;
    i_i2cs_master_model.tick(4);
    addrPhase(1'b0, 1'b1);
    i_i2cs_master_model.stop();
    timerReload <= {12'hfff, 4'(xs())};
    for (int m = 0; m < 3; m++)
    begin
      timeoutEnable <= (m != 0);
      timerReloadSourceSel <= (m != 1);
      events = 0;
      i_i2cs_master_model.holdLow(40);
      check("timeout seen", 16'(events != 0), 16'(m == 2));
    end
    check("timer reload", timerCount, timerReload);
    check("master hangs", 16'(i_i2cs_master_model.hangs), 16'h0000);
    finalReport();
  end
endmodule
